// *** hw/hcrd_top.sv ***
`timescale 1ns/1ns
// What this block does
// R1 - asynchronous commands only arm receive DMA
// R2 - host loads address, count, then code
// R3 - probe word, queue pair, post status
// R4 - oldest queued buffer takes received data
// R5 - receive done set; commands still accepted
// R6 - enable gates interrupt; clearing withdraws it
// R7 - status field loaded; host writes ignored
// R8 - address register write-only, sixteen bits
// R9 - host loads both before DMA commands
// R10 - count write-only; zero gives memory error
// R11 - code zero completes as illegal command
// R12 - host writes code into bits 13:8
// R13 - module loopback: transmit into receive, offline
// R14 - data loopback bypasses CRC generator
// R15 - internal loopback before cable, offline
// R16 - internal loopback frames pass receive filter
// R17 - mode changes keep receive FIFO contents
// R18 - clear loopback leaves either loopback mode
// R19 - indicator on during internal loopback only
// R20 - promiscuous accepts all destinations; own frames no CRC
// R21 - normal: physical, multicast, broadcast only
// R22 - receive-on-error delivers and flags errors
// R23 - non-DMA commands execute, post status, done
// R24 - errored frames dropped without receive-on-error
// R25 - send while offline is inappropriate command
// R26 - new command clears command done
module hcrd_top #(
  parameter int QUEUE_DEPTH = hcrd_pkg::RXQ_DEPTH
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // host register port
  input  wire logic [1:0]  reg_sel,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  output logic             rx_irq,
  // host memory DMA master
  output logic             dma_req,
  output logic      [15:0] dma_addr,
  output logic      [15:0] dma_wdata,
  input  wire logic        dma_ack,
  input  wire logic        dma_nxm,
  // network receive FIFO stream
  input  wire logic        net_valid,
  output logic             net_ready,
  input  wire logic [15:0] net_data,
  input  wire logic        net_first,
  input  wire logic        net_last,
  input  wire logic        net_crc_err,
  input  wire logic        net_align_err,
  input  wire logic        net_fragment,
  input  wire logic        net_own,
  input  wire logic        net_phys_match,
  input  wire logic        net_mcast_match,
  input  wire logic        net_bcast_match,
  // looped transmit stream
  input  wire logic        loop_valid,
  output logic             loop_ready,
  input  wire logic [15:0] loop_data,
  input  wire logic        loop_first,
  input  wire logic        loop_last,
  input  wire logic        loop_phys_match,
  input  wire logic        loop_mcast_match,
  input  wire logic        loop_bcast_match,
  // mode outputs
  output logic             offline,
  output logic             loop_module,
  output logic             loop_internal,
  output logic             crc_bypass,
  output logic             promiscuous,
  output logic             rx_on_error,
  output logic             pass_fail_led
);
  typedef struct packed {
    hcrd_pkg::hcrd_cmd_state_type cmd_state;  // command sequencer
    hcrd_pkg::hcrd_rx_state_type  rx_state;   // receive DMA engine
    logic [5:0]  cmd_code;     // last command written
    logic [3:0]  status;       // posted status code
    logic        cmd_done;     // command complete
    logic        rx_done;      // receive transfer complete
    logic        rx_ie;        // receive interrupt enable
    logic [15:0] bar;          // buffer base address
    logic [15:0] dma_buffer_length;          // buffer byte count
    logic        loop_module;
    logic        loop_internal;
    logic        offline;
    logic        promisc;
    logic        roe;          // receive-on-error
    logic        dma_req;
    logic [15:0] dma_addr;
    logic [15:0] dma_wdata;
    logic [15:0] rx_addr;      // current receive buffer pointer
    logic [15:0] rx_cnt;       // bytes left in receive buffer
    logic [15:0] rdata;        // register read data
  } hcrd_state_type;

  hcrd_state_type r;
  hcrd_state_type n;

  logic [1:0]  rst_pipe;     // reset release synchroniser
  logic        rst_sync_n;   // synchronised reset
  logic        q_push;
  logic        q_pop;
  logic        q_flush;
  logic [15:0] q_head_addr;
  logic [15:0] q_head_len;
  logic        q_empty;
  logic        q_full;
  logic        s_valid;      // selected receive source
  logic        s_ready;
  logic [15:0] s_data;
  logic        s_first;
  logic        s_last;
  logic        s_crc;
  logic        s_align;
  logic        s_frag;
  logic        s_phys;
  logic        s_mcast;
  logic        s_bcast;
  logic        s_accept;
  logic        any_loop;
  logic        rx_owns_dma;  // receive engine mid-transfer

  // counts down a buffer, never below zero
  function automatic logic [15:0] dec_count(input logic [15:0] c);
    dec_count = (c >= hcrd_pkg::WORD_BYTES) ? c - hcrd_pkg::WORD_BYTES : 16'h0000;
  endfunction

  // status of non-supply commands
  function automatic logic [3:0] status_for(input logic [5:0] c, input logic off,
                                            input logic cnt_zero);
    status_for = hcrd_pkg::ST_SUCCESS;
    // R11 reserved code zero
    if (c == hcrd_pkg::CMD_RESERVED) begin
      status_for = hcrd_pkg::ST_ILLEGAL;
    end else if ((c >= 6'h14 && c <= 6'h17) || (c >= 6'h1B && c <= 6'h1F) ||
                 (c >= 6'h21 && c <= 6'h27) || (c >= 6'h2D && c <= 6'h2F) ||
                 (c >= 6'h31 && c <= 6'h3E)) begin
      // reserved and undefined codes
      status_for = hcrd_pkg::ST_ILLEGAL;
    end else if (c == hcrd_pkg::CMD_LOAD_SEND && off) begin
      // R25 no send while offline
      status_for = hcrd_pkg::ST_INAPPR;
    end else if ((c >= 6'h18 && c <= 6'h1A) || (c >= 6'h28 && c <= 6'h2C)) begin
      // R10 zero count on DMA commands
      if (cnt_zero) begin
        status_for = hcrd_pkg::ST_NXM;
      end
    end
  endfunction

  // async assert, release through two flops
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_pipe[1];

  // R13 looped frames replace network input
  always_comb begin
    any_loop = r.loop_module || r.loop_internal;
    s_valid  = any_loop ? loop_valid : net_valid;
    s_data   = any_loop ? loop_data  : net_data;
    s_first  = any_loop ? loop_first : net_first;
    s_last   = any_loop ? loop_last  : net_last;
    s_phys   = any_loop ? loop_phys_match  : net_phys_match;
    s_mcast  = any_loop ? loop_mcast_match : net_mcast_match;
    s_bcast  = any_loop ? loop_bcast_match : net_bcast_match;
    s_align  = any_loop ? 1'b0 : net_align_err;
    s_frag   = any_loop ? 1'b0 : net_fragment;
    // R20 own frames skip the CRC check in promiscuous mode
    s_crc    = any_loop ? 1'b0 : (net_crc_err && !(r.promisc && net_own));
  end

  // R16 internal loopback filters addresses
  hcrd_frame_filter u_filter (
    .promisc         (r.promisc),
    .rx_on_error     (r.roe),
    .use_addr_filter (!r.loop_module),
    .fragment        (s_frag),
    .crc_err         (s_crc),
    .align_err       (s_align),
    .phys_match      (s_phys),
    .mcast_match     (s_mcast),
    .bcast_match     (s_bcast),
    .accept          (s_accept)
  );

  hcrd_rx_queue #(.DEPTH(QUEUE_DEPTH)) u_queue (
    .mclk       (mclk),
    .rst_sync_n (rst_sync_n),
    .push       (q_push),
    .pop        (q_pop),
    .flush      (q_flush),
    .push_addr  (r.bar),
    .push_len   (r.dma_buffer_length),
    .head_addr  (q_head_addr),
    .head_len   (q_head_len),
    .empty      (q_empty),
    .full       (q_full)
  );

  // next state of the whole block
  always_comb begin
    n           = r;
    q_push      = 1'b0;
    q_pop       = 1'b0;
    q_flush     = 1'b0;
    s_ready     = 1'b0;
    rx_owns_dma = (r.rx_state == hcrd_pkg::RX_STAT) || (r.rx_state == hcrd_pkg::RX_DATA);

    // R8 R10 address and count hold last write
    if (reg_wr) begin
      case (reg_sel)
        hcrd_pkg::REG_BAR: begin
          n.bar = reg_wdata;
        end
        hcrd_pkg::REG_BCR: begin
          n.dma_buffer_length = reg_wdata;
        end
        hcrd_pkg::REG_CSR: begin
          // R6 zero withdraws a pending request
          n.rx_ie = reg_wdata[hcrd_pkg::CSR_RX_IE_BIT];
          if (!reg_wdata[hcrd_pkg::CSR_RX_DONE]) begin
            n.rx_done = 1'b0;
          end
          // R26 new command clears done
          if (r.cmd_state == hcrd_pkg::CMD_IDLE) begin
            n.cmd_code  = reg_wdata[hcrd_pkg::CSR_CMD_LSB +: hcrd_pkg::CSR_CMD_W];
            n.cmd_done  = 1'b0;
            n.cmd_state = hcrd_pkg::CMD_EXEC;
          end
        end
        default: begin
        end
      endcase
    end

    // R7 R8 R10 status as posted, others read zero
    if (reg_rd) begin
      n.rdata = (reg_sel == hcrd_pkg::REG_CSR) ?
                {r.rx_done, 1'b0, r.cmd_code, r.cmd_done, r.rx_ie, 2'b00, r.status} :
                16'h0000;
    end

    // command sequencer
    case (r.cmd_state)
      hcrd_pkg::CMD_IDLE: begin
      end
      hcrd_pkg::CMD_EXEC: begin
        n.cmd_state = hcrd_pkg::CMD_IDLE;
        n.cmd_done  = 1'b1;
        if (r.cmd_code == hcrd_pkg::CMD_SUPPLY_RX) begin
          // R10 zero count gives memory error
          if (r.dma_buffer_length == 16'h0000) begin
            n.status = hcrd_pkg::ST_NXM;
          end else if (q_full) begin
            n.status = hcrd_pkg::ST_INAPPR;
          end else begin
            // R1 arm only, transfer waits for a frame
            n.cmd_done  = 1'b0;
            n.cmd_state = hcrd_pkg::CMD_PROBE;
          end
        end else begin
          // R23 execute and post status
          n.status = status_for(r.cmd_code, r.offline, r.dma_buffer_length == 16'h0000);
          case (r.cmd_code)
            // R13 R14 module loopback, offline
            hcrd_pkg::CMD_LOOP_MOD: begin
              n.loop_module   = 1'b1;
              n.loop_internal = 1'b0;
              n.offline       = 1'b1;
            end
            // R15 R17 internal loopback, queue kept
            hcrd_pkg::CMD_LOOP_INT: begin
              n.loop_internal = 1'b1;
              n.loop_module   = 1'b0;
              n.offline       = 1'b1;
            end
            // R18 leave either loopback
            hcrd_pkg::CMD_LOOP_CLR: begin
              n.loop_module   = 1'b0;
              n.loop_internal = 1'b0;
            end
            // R20 accept all destinations
            hcrd_pkg::CMD_PROM_SET: begin
              n.promisc = 1'b1;
            end
            // R21 R17 address filter, queue kept
            hcrd_pkg::CMD_PROM_CLR: begin
              n.promisc = 1'b0;
            end
            // R22 deliver errored frames
            hcrd_pkg::CMD_ROE_SET: begin
              n.roe = 1'b1;
            end
            // R24 drop errored frames
            hcrd_pkg::CMD_ROE_CLR: begin
              n.roe = 1'b0;
            end
            // online state frozen in loopback
            hcrd_pkg::CMD_OFFLINE: begin
              n.offline = any_loop ? r.offline : 1'b1;
            end
            hcrd_pkg::CMD_ONLINE: begin
              n.offline = any_loop ? r.offline : 1'b0;
            end
            hcrd_pkg::CMD_FLUSH_RXQ: begin
              q_flush = 1'b1;
            end
            hcrd_pkg::CMD_RESET: begin
              q_flush         = 1'b1;
              n.loop_module   = 1'b0;
              n.loop_internal = 1'b0;
              n.promisc       = 1'b0;
              n.roe           = 1'b0;
              n.offline       = hcrd_pkg::OFFLINE_RESET;
            end
            default: begin
            end
          endcase
        end
      end
      hcrd_pkg::CMD_PROBE: begin
        // R3 probe one word, then queue
        if (!r.dma_req && !rx_owns_dma) begin
          n.dma_req   = 1'b1;
          n.dma_addr  = r.bar;
          n.dma_wdata = 16'h0000;
        end else if (r.dma_req && !rx_owns_dma && dma_ack) begin
          n.dma_req   = 1'b0;
          n.cmd_done  = 1'b1;
          n.cmd_state = hcrd_pkg::CMD_IDLE;
          n.status    = dma_nxm ? hcrd_pkg::ST_NXM : hcrd_pkg::ST_SUCCESS;
          q_push      = !dma_nxm;
        end
      end
      default: begin
        n.cmd_state = hcrd_pkg::CMD_IDLE;
      end
    endcase

    // R5 receive engine beside sequencer
    case (r.rx_state)
      hcrd_pkg::RX_IDLE: begin
        if (s_valid) begin
          if (!s_first || !s_accept || (r.offline && !any_loop)) begin
            // R24 rejected frames are consumed unseen
            s_ready = 1'b1;
            if (s_first && !s_last) begin
              n.rx_state = hcrd_pkg::RX_DROP;
            end
          end else if (!q_empty && r.cmd_state != hcrd_pkg::CMD_PROBE) begin
            // R4 oldest buffer first
            q_pop       = 1'b1;
            n.rx_addr   = q_head_addr + hcrd_pkg::WORD_BYTES;
            n.rx_cnt    = dec_count(q_head_len);
            n.dma_req   = 1'b1;
            n.dma_addr  = q_head_addr;
            // R22 error flags at head of packet
            n.dma_wdata = 16'h0000;
            n.dma_wdata[hcrd_pkg::FS_CRC_BIT]   = s_crc;
            n.dma_wdata[hcrd_pkg::FS_ALIGN_BIT] = s_align;
            n.rx_state  = hcrd_pkg::RX_STAT;
          end
        end
      end
      hcrd_pkg::RX_DROP: begin
        s_ready = s_valid;
        if (s_valid && s_last) begin
          n.rx_state = hcrd_pkg::RX_IDLE;
        end
      end
      hcrd_pkg::RX_STAT: begin
        if (dma_ack) begin
          n.dma_req  = 1'b0;
          n.rx_state = hcrd_pkg::RX_DATA;
        end
      end
      hcrd_pkg::RX_DATA: begin
        if (!r.dma_req) begin
          if (s_valid && r.rx_cnt == 16'h0000) begin
            // buffer full: frame tail lost
            s_ready = 1'b1;
            if (s_last) begin
              n.rx_state = hcrd_pkg::RX_DONE;
            end
          end else if (s_valid) begin
            n.dma_req   = 1'b1;
            n.dma_addr  = r.rx_addr;
            n.dma_wdata = s_data;
          end
        end else if (dma_ack) begin
          n.dma_req = 1'b0;
          s_ready   = 1'b1;
          n.rx_addr = r.rx_addr + hcrd_pkg::WORD_BYTES;
          n.rx_cnt  = dec_count(r.rx_cnt);
          if (s_last) begin
            n.rx_state = hcrd_pkg::RX_DONE;
          end
        end
      end
      hcrd_pkg::RX_DONE: begin
        // R5 set after the clear, so set wins
        n.rx_done  = 1'b1;
        n.rx_state = hcrd_pkg::RX_IDLE;
      end
      default: begin
        n.rx_state = hcrd_pkg::RX_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      r         <= '0;
      r.offline <= hcrd_pkg::OFFLINE_RESET;
    end else begin
      r <= n;
    end
  end

  // handshakes back to the sources
  assign net_ready  = !any_loop && s_ready;
  assign loop_ready = any_loop && s_ready;

  // outputs
  assign reg_rdata     = r.rdata;
  assign rx_irq        = r.rx_done && r.rx_ie;
  assign dma_req       = r.dma_req;
  assign dma_addr      = r.dma_addr;
  assign dma_wdata     = r.dma_wdata;
  assign offline       = r.offline;
  assign loop_module   = r.loop_module;
  assign loop_internal = r.loop_internal;
  assign crc_bypass    = any_loop;
  assign promiscuous   = r.promisc;
  assign rx_on_error   = r.roe;
  // R19 led on in internal loopback
  assign pass_fail_led = r.loop_internal;
endmodule

// *** shared/hcrd_pkg.sv ***
package hcrd_pkg;

  // register select codes
  localparam logic [1:0] REG_CSR = 2'h0;
  localparam logic [1:0] REG_BAR = 2'h1;
  localparam logic [1:0] REG_BCR = 2'h2;

  // command and status field positions
  localparam int CSR_STATUS_LSB = 0;
  localparam int CSR_STATUS_W   = 4;
  localparam int CSR_RX_IE_BIT  = 6;
  localparam int CSR_CMD_DONE   = 7;
  localparam int CSR_CMD_LSB    = 8;
  localparam int CSR_CMD_W      = 6;
  localparam int CSR_RX_DONE    = 15;

  // reset values
  localparam logic [15:0] CSR_RESET     = 16'h0000;
  localparam logic        OFFLINE_RESET = 1'b1;

  // command codes, in hex
  localparam logic [5:0] CMD_RESERVED   = 6'h00;
  localparam logic [5:0] CMD_LOOP_MOD   = 6'h01;
  localparam logic [5:0] CMD_LOOP_INT   = 6'h02;
  localparam logic [5:0] CMD_LOOP_CLR   = 6'h03;
  localparam logic [5:0] CMD_PROM_SET   = 6'h04;
  localparam logic [5:0] CMD_PROM_CLR   = 6'h05;
  localparam logic [5:0] CMD_ROE_SET    = 6'h06;
  localparam logic [5:0] CMD_ROE_CLR    = 6'h07;
  localparam logic [5:0] CMD_OFFLINE    = 6'h08;
  localparam logic [5:0] CMD_ONLINE     = 6'h09;
  localparam logic [5:0] CMD_SUPPLY_RX  = 6'h20;
  localparam logic [5:0] CMD_LOAD_SEND  = 6'h29;
  localparam logic [5:0] CMD_FLUSH_RXQ  = 6'h30;
  localparam logic [5:0] CMD_RESET      = 6'h3F;

  // status codes
  localparam logic [3:0] ST_SUCCESS = 4'h0;
  localparam logic [3:0] ST_ILLEGAL = 4'h2;
  localparam logic [3:0] ST_INAPPR  = 4'h3;
  localparam logic [3:0] ST_NXM     = 4'hF;

  // frame status word bits
  localparam int FS_CRC_BIT   = 0;
  localparam int FS_ALIGN_BIT = 1;

  // bytes per host memory word
  localparam logic [15:0] WORD_BYTES = 16'h0002;

  // default depth of the receive buffer queue
  localparam int RXQ_DEPTH = 4;

  typedef enum logic [1:0] {CMD_IDLE, CMD_EXEC, CMD_PROBE} hcrd_cmd_state_type;
  typedef enum logic [2:0] {RX_IDLE, RX_DROP, RX_STAT, RX_DATA, RX_DONE} hcrd_rx_state_type;

endpackage

// *** hw/hcrd_rx_queue.sv ***
`timescale 1ns/1ns
// fifo of buffer address and byte count pairs
module hcrd_rx_queue #(
  parameter int DEPTH = hcrd_pkg::RXQ_DEPTH
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_sync_n,
  // control
  input  wire logic        push,
  input  wire logic        pop,
  input  wire logic        flush,
  // entry in
  input  wire logic [15:0] push_addr,
  input  wire logic [15:0] push_len,
  // head entry and fill state
  output logic      [15:0] head_addr,
  output logic      [15:0] head_len,
  output logic             empty,
  output logic             full
);
  localparam int PW = $clog2(DEPTH);

  // pointer wrap needs a power of two
  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("queue depth must be a power of two of at least 2");
    end
  endgenerate

  typedef struct packed {
    logic [DEPTH-1:0][31:0] mem;   // address high, count low
    logic [PW-1:0]          rd;    // oldest entry
    logic [PW-1:0]          wr;    // next free slot
    logic [PW:0]            cnt;   // entries held
  } hcrd_q_type;

  hcrd_q_type r;
  hcrd_q_type n;

  assign empty     = (r.cnt == '0);
  assign full      = (r.cnt == (PW+1)'(DEPTH));
  assign head_addr = r.mem[r.rd][31:16];
  assign head_len  = r.mem[r.rd][15:0];

  // next state: flush wins, then pop and push
  always_comb begin
    n = r;
    if (flush) begin
      n.rd  = '0;
      n.wr  = '0;
      n.cnt = '0;
    end else begin
      // oldest first, order supplied
      if (pop && !empty) begin
        n.rd  = r.rd + 1'b1;
      end
      if (push && !full) begin
        n.mem[r.wr] = {push_addr, push_len};
        n.wr        = r.wr + 1'b1;
      end
      n.cnt = r.cnt + (PW+1)'(push && !full) - (PW+1)'(pop && !empty);
    end
  end

  // state register
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
endmodule

// *** hw/hcrd_frame_filter.sv ***
`timescale 1ns/1ns
// decides whether a frame reaches the host
module hcrd_frame_filter (
  // mode
  input  wire logic promisc,
  input  wire logic rx_on_error,
  input  wire logic use_addr_filter,
  // frame facts
  input  wire logic fragment,
  input  wire logic crc_err,
  input  wire logic align_err,
  input  wire logic phys_match,
  input  wire logic mcast_match,
  input  wire logic bcast_match,
  // decision
  output logic      accept
);
  logic addr_ok;   // destination passes
  logic err_ok;    // error state passes

  // destination check, skipped in promiscuous mode
  assign addr_ok = promisc || !use_addr_filter || phys_match || mcast_match || bcast_match;

  // errored frames only pass in receive-on-error mode
  assign err_ok = rx_on_error || !(crc_err || align_err);

  // collision fragments never pass
  assign accept = !fragment && addr_ok && err_ok;
endmodule

// *** bench/hcrd_properties.sv ***
`timescale 1ns/1ns
// port checker
module hcrd_properties (
  // clock and reset
  input wire logic        mclk,
  input wire logic        rst_n,
  // host side
  input wire logic [1:0]  reg_sel,
  input wire logic        reg_wr,
  input wire logic [15:0] reg_wdata,
  input wire logic        rx_irq,
  // dma side
  input wire logic        dma_req,
  input wire logic        dma_ack,
  input wire logic [15:0] dma_addr,
  input wire logic [15:0] dma_wdata,
  // modes
  input wire logic        offline,
  input wire logic        loop_module,
  input wire logic        loop_internal,
  input wire logic        crc_bypass,
  input wire logic        promiscuous,
  input wire logic        rx_on_error,
  input wire logic        pass_fail_led
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_irq_off; reg_wr && reg_sel == 2'h0 && !reg_wdata[6] |=> !rx_irq; endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("irq up after enable cleared");
  property p_led; pass_fail_led == loop_internal; endproperty
  a_led: assert property (p_led)
    else $error("led not internal loopback");
  property p_crc; crc_bypass == (loop_module || loop_internal); endproperty
  a_crc: assert property (p_crc)
    else $error("crc bypass wrong");
  property p_loop_off; loop_module || loop_internal |-> offline; endproperty
  a_loop_off: assert property (p_loop_off)
    else $error("loopback while online");
  property p_hold; dma_req && !dma_ack |=> dma_req && $stable(dma_addr) && $stable(dma_wdata);
  endproperty
  a_hold: assert property (p_hold)
    else $error("dma changed before ack");
  property p_drop; dma_req && dma_ack |=> !dma_req; endproperty
  a_drop: assert property (p_drop)
    else $error("dma held after ack");
  property p_done; $rose(rx_irq) && !$past(reg_wr) |-> $past(dma_ack, 2) || $past(dma_ack, 3);
  endproperty
  a_done: assert property (p_done)
    else $error("receive done without transfer");
  // promiscuous and receive-on-error modes move only on a command
  property p_modes; $changed(promiscuous) || $changed(rx_on_error)
    |-> $past(reg_wr) || $past(reg_wr, 2); endproperty
  a_modes: assert property (p_modes)
    else $error("mode changed with no command");
endmodule

// *** bench/hcrd_host_mem.sv ***
`timescale 1ns/1ns
// host memory, acks alternate fast and slow
module hcrd_host_mem #(
  parameter logic [15:0] NXM_BASE = 16'hF000
) (
  input  wire logic        mclk,
  input  wire logic        dma_req,
  input  wire logic [15:0] dma_addr,
  input  wire logic [15:0] dma_wdata,
  output logic             dma_ack,
  output logic             dma_nxm
);
  logic [15:0] mem [0:255]; // word store
  logic [1:0]  wait_cnt;    // stall counter
  logic        slow;        // next answer is slow
  logic        junk;        // nxm is noise outside ack
  initial {dma_ack, wait_cnt, slow, junk} = '0;
  // ack after 0 or 3 idle cycles; nxm region stores nothing
  always @(posedge mclk) begin
    junk <= ~junk;
    if (dma_req && !dma_ack) begin
      if (wait_cnt == (slow ? 2'h3 : 2'h0)) begin
        dma_ack <= 1'b1;
        if (dma_addr < NXM_BASE) mem[dma_addr[8:1]] <= dma_wdata;
        slow <= ~slow;
        wait_cnt <= 2'h0;
      end else wait_cnt <= wait_cnt + 2'h1;
    end else dma_ack <= 1'b0;
  end
  assign dma_nxm = dma_ack ? (dma_addr >= NXM_BASE) : junk;
endmodule

// *** bench/testbench.sv ***
`timescale 1ns/1ns
// register tasks, frame driver and checks
module testbench;
  logic        mclk, rst_n, reg_wr, reg_rd, net_valid, loop_valid, net_first, net_last, ie;
  logic [1:0]  reg_sel;
  logic [15:0] reg_wdata, net_data, rd_val;
  logic [6:0]  fx; // crc, align, fragment, own, phys, mcast, bcast
  int          n_errors, checks;
  wire logic [15:0] reg_rdata, dma_addr, dma_wdata;
  wire logic rx_irq, dma_req, dma_ack, dma_nxm, net_ready, loop_ready, offline, loop_module;
  wire logic loop_internal, crc_bypass, promiscuous, rx_on_error, pass_fail_led;
  logic [5:0]  mc [8] = '{6'h01, 6'h03, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07};
  logic [15:0] me [8] = '{16'h70, 16'h40, 16'h69, 16'h40, 16'h44, 16'h40, 16'h42, 16'h40};
  // small queue reaches full quickly
  hcrd_top #(.QUEUE_DEPTH(2)) uut (.*, .net_crc_err(fx[6]), .net_align_err(fx[5]),
    .net_fragment(fx[4]), .net_own(fx[3]), .net_phys_match(fx[2]), .net_mcast_match(fx[1]),
    .net_bcast_match(fx[0]), .loop_data(net_data), .loop_first(net_first),
    .loop_last(net_last), .loop_phys_match(fx[2]), .loop_mcast_match(fx[1]),
    .loop_bcast_match(fx[0]));
  hcrd_host_mem mem_model (.*);
  always #5 mclk = ~mclk;
  function automatic logic [15:0] modes();
    return {9'h0, offline, crc_bypass, loop_module, loop_internal, promiscuous, rx_on_error,
      pass_fail_led};
  endfunction
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task summarize;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task wr(input logic [1:0] s, input logic [15:0] d);
    @(posedge mclk);
    reg_sel <= s;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [1:0] s);
    @(posedge mclk);
    reg_sel <= s;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    rd_val = reg_rdata;
  endtask
  // status bits set in write data: host writes there are ignored
  task cmd(input logic [5:0] c, input logic [3:0] st);
    int n;
    wr(2'h0, {2'h0, c, 1'b1, ie, 6'h0F});
    n = 0;
    do begin rd(2'h0); n++; end while (rd_val[7] !== 1'b1 && n < 50);
    chk(rd_val & 16'h3F8F, {2'h0, c, 4'h8, st});
    if (n >= 50) summarize();
  endtask
  // one word, held until ready
  task send(input logic lp, input logic [15:0] d, input logic f, input logic l);
    int n;
    @(posedge mclk);
    net_data <= d;
    net_first <= f;
    net_last <= l;
    if (lp) loop_valid <= 1'b1;
    else net_valid <= 1'b1;
    n = 0;
    do begin @(negedge mclk); n++; end while ((lp ? loop_ready : net_ready) !== 1'b1 && n < 300);
    if (n >= 300) begin n_errors++; summarize(); end
    @(posedge mclk);
    net_valid <= 1'b0;
    loop_valid <= 1'b0;
  endtask
  task wait_irq;
    int n;
    n = 0;
    while (rx_irq !== 1'b1 && n < 300) begin @(negedge mclk); n++; end
    chk({15'h0, rx_irq}, 16'h1);
    if (n >= 300) summarize();
  endtask
  initial begin
    {mclk, rst_n, reg_wr, reg_rd, net_valid, loop_valid, net_first, net_last, ie} = '0;
    {reg_sel, reg_wdata, net_data, fx, n_errors, checks} = '0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    rd(2'h0);
    chk(rd_val, 16'h0000);
    chk(modes(), 16'h40);
    cmd(6'h00, 4'h2);
    for (int i = 0; i < 8; i++) begin
      cmd(mc[i], 4'h0);
      chk(modes(), me[i]);
    end
    for (int s = 1; s < 4; s++) begin
      wr(s[1:0], 16'hFFFF);
      rd(s[1:0]);
      chk(rd_val, 16'h0000);
    end
    wr(2'h1, 16'h0040);
    wr(2'h2, 16'h0000);
    cmd(6'h20, 4'hF);
    wr(2'h1, 16'hF000);
    wr(2'h2, 16'h0008);
    cmd(6'h20, 4'hF);
    cmd(6'h09, 4'h0);
    ie = 1'b1;
    wr(2'h1, 16'h0040);
    cmd(6'h20, 4'h0);
    wr(2'h1, 16'h0080);
    cmd(6'h20, 4'h0);
    wr(2'h1, 16'h00C0);
    cmd(6'h20, 4'h3);
    fx = 7'h44;
    send(1'b0, 16'h1111, 1'b1, 1'b1);
    fx = 7'h04;
    send(1'b0, 16'hAAAA, 1'b1, 1'b0);
    send(1'b0, 16'hBBBB, 1'b0, 1'b1);
    wait_irq();
    chk(mem_model.mem[8'h20], 16'h0000);
    chk(mem_model.mem[8'h21], 16'hAAAA);
    chk(mem_model.mem[8'h22], 16'hBBBB);
    ie = 1'b0;
    cmd(6'h06, 4'h0);
    chk({15'h0, rx_irq}, 16'h0);
    ie = 1'b1;
    cmd(6'h04, 4'h0);
    fx = 7'h40;
    send(1'b0, 16'hCCCC, 1'b1, 1'b1);
    wait_irq();
    chk(mem_model.mem[8'h40], 16'h0001);
    chk(mem_model.mem[8'h41], 16'hCCCC);
    cmd(6'h02, 4'h0);
    wr(2'h1, 16'h00C0);
    cmd(6'h20, 4'h0);
    fx = 7'h04;
    send(1'b1, 16'hDDDD, 1'b1, 1'b1);
    wait_irq();
    chk(mem_model.mem[8'h61], 16'hDDDD);
    summarize();
  end
endmodule
bind hcrd_top hcrd_properties u_props (.*);
